// >>> dv/mpp_board.sv
// Board model: resolves the pad levels of ports zero to five.
// Assumes oe high means the device drives or pulls the pin.
`timescale 1ns/1ps
`default_nettype none
module mpp_board (
  // Clock
  input  wire logic        sys_clk,
  // Port zero pads and board driver
  input  wire logic [7:0]  p0_out,
  input  wire logic [7:0]  p0_oe,
  input  wire logic [7:0]  p0_drv,
  input  wire logic        p0_drv_en,
  output logic      [7:0]  p0_pin,
  // Quasi pads, ports one to five, port one on top
  input  wire logic [39:0] q_out,
  input  wire logic [39:0] q_oe,
  input  wire logic [39:0] q_pull_low,
  output logic      [39:0] q_pin
);
  logic [7:0] last_r;
  // Released open-drain pin has no pullup: undriven shows a moving value
  assign p0_pin = (p0_oe & p0_out) |
                  (~p0_oe & (p0_drv_en ? p0_drv : ~last_r));
  // Pullup wins unless device or board pulls low
  assign q_pin = (q_oe & q_out) | (~q_oe & ~q_pull_low);
  always_ff @(posedge sys_clk) begin
    last_r <= p0_pin;
  end
endmodule
`default_nettype wire

// >>> dv/mpp_ports_bench.sv
// Self-checking bench for the port block.
// Assumes the board model resolves pads; SFR read answers next cycle.
`timescale 1ns/1ps
`default_nettype none
`include "mpp_params.svh"
module mpp_ports_bench;
  import mpp_pkg::*;
  logic sys_clk = 1'b0, reset = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, ext_wdata = 8'h00;
  logic ext_addr_phase = 1'b0, ext_data_out = 1'b0, ext_access = 1'b0;
  logic ext_data_access = 1'b0, ext_wr_n = 1'b1, ext_rd_n = 1'b1;
  logic system_clock_src = 1'b1, serial_data_out = 1'b1;
  logic serial_txd_or_clk = 1'b1;
  logic [3:0] ccu_compare_out = 4'hf;
  logic [15:0] ext_addr = 16'h0000;
  logic [7:0] analog_digital_input_port = 8'h00, p0_drv = 8'hff;
  logic [39:0] pull_low = 40'h0;
  logic [7:0] sfr_rdata, ext_rdata, port_zero_in, port_zero_out;
  logic [7:0] port_zero_oe, port_zero_strong, port_one_in, port_one_out;
  logic [7:0] port_one_oe, port_two_in, port_two_out, port_two_oe;
  logic [7:0] port_three_in, port_three_out, port_three_oe, port_four_in;
  logic [7:0] port_four_out, port_four_oe, port_five_in, port_five_out;
  logic [7:0] port_five_oe, m;
  logic [3:0] irq_three_ccu_chan_zero_pin;
  logic irq_two_pin, third_timer_reload_trigger, third_timer_count_gate_pin;
  logic serial_data_in, irq_zero_pin, irq_one_pin, timer_zero_count_pin;
  logic timer_one_count_pin;
  int bad_count = 0, n_tests = 0;
  localparam logic [7:0] LAT [6] = '{`MPP_ADDR_PORT_ZERO,
    `MPP_ADDR_PORT_ONE, `MPP_ADDR_PORT_TWO, `MPP_ADDR_PORT_THREE,
    `MPP_ADDR_PORT_FOUR, `MPP_ADDR_PORT_FIVE};
  always #5 sys_clk = ~sys_clk;
  mpp_ports mpp_ports_i (.sys_clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .ext_addr_phase, .ext_data_out, .ext_access,
    .ext_data_access, .ext_addr, .ext_wdata, .ext_rdata, .ext_wr_n,
    .ext_rd_n, .ccu_compare_out, .system_clock_src, .serial_data_out,
    .serial_txd_or_clk, .irq_three_ccu_chan_zero_pin, .irq_two_pin,
    .third_timer_reload_trigger, .third_timer_count_gate_pin,
    .serial_data_in, .irq_zero_pin, .irq_one_pin, .timer_zero_count_pin,
    .timer_one_count_pin, .analog_digital_input_port, .port_zero_in,
    .port_zero_out, .port_zero_oe, .port_zero_strong, .port_one_in,
    .port_one_out, .port_one_oe, .port_two_in, .port_two_out, .port_two_oe,
    .port_three_in, .port_three_out, .port_three_oe, .port_four_in,
    .port_four_out, .port_four_oe, .port_five_in, .port_five_out,
    .port_five_oe);
  mpp_board mpp_board_i (.sys_clk, .p0_out(port_zero_out),
    .p0_oe(port_zero_oe), .p0_drv, .p0_drv_en(1'b1), .p0_pin(port_zero_in),
    .q_out({port_one_out, port_two_out, port_three_out, port_four_out,
            port_five_out}),
    .q_oe({port_one_oe, port_two_oe, port_three_oe, port_four_oe,
           port_five_oe}),
    .q_pull_low(pull_low),
    .q_pin({port_one_in, port_two_in, port_three_in, port_four_in,
            port_five_in}));
  // ==========================================================
  // Tasks
  task automatic chk(input string what, input mpp_byte_t exp,
                     input mpp_byte_t got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input mpp_byte_t d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input mpp_byte_t exp);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1 chk("sfr read", exp, sfr_rdata);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (3000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    settle();
    chk("p0 oe", 8'h00, port_zero_oe);
    foreach (LAT[i]) rd_chk(LAT[i], 8'hff);
    $display("reset test done");
    foreach (LAT[i]) wr(LAT[i], 8'h5a ^ 8'(i));
    foreach (LAT[i]) rd_chk(LAT[i], 8'h5a ^ 8'(i));
    chk("p0 oe", 8'ha5, port_zero_oe);
    chk("p0 strong", 8'h00, port_zero_strong);
    $display("latch test done");
    wr(`MPP_ADDR_PORT_ONE, 8'hff);
    wr(`MPP_ADDR_PORT_THREE, 8'hff);
    for (int k = 0; k < 2; k++) begin
      m = k ? 8'haa : 8'h55;
      pull_low <= {m, 8'h00, m, 16'h0};
      settle();
      chk("p1 alt in", ~m & 8'hbf, {third_timer_count_gate_pin, 1'b0,
          third_timer_reload_trigger, irq_two_pin,
          irq_three_ccu_chan_zero_pin});
      chk("p3 alt in", ~m & 8'h3d, {2'b00, timer_one_count_pin,
          timer_zero_count_pin, irq_one_pin, irq_zero_pin, 1'b0,
          serial_data_in});
      rd_chk(`MPP_ADDR_PORT_ONE, ~m);
    end
    pull_low <= 40'h0;
    ext_data_access <= 1'b1;
    {ccu_compare_out, system_clock_src, serial_data_out} <= 6'b010100;
    {serial_txd_or_clk, ext_wr_n, ext_rd_n} <= 3'b101;
    settle();
    chk("p1 oe", 8'h4a, port_one_oe);
    chk("p3 oe", 8'h41, port_three_oe);
    {ccu_compare_out, system_clock_src, serial_data_out} <= 6'b101011;
    {serial_txd_or_clk, ext_wr_n, ext_rd_n} <= 3'b010;
    settle();
    chk("p1 oe", 8'h05, port_one_oe);
    chk("p3 oe", 8'h82, port_three_oe);
    $display("alternate test done");
    {ccu_compare_out, system_clock_src, serial_data_out} <= 6'b111111;
    {serial_txd_or_clk, ext_wr_n, ext_rd_n, ext_data_access} <= 4'b1110;
    {ext_access, ext_addr_phase, ext_addr} <= {2'b11, 16'h12c3};
    settle();
    chk("p0 addr", 8'hc3, port_zero_out);
    chk("p0 oe", 8'hff, port_zero_oe);
    chk("p0 strong", 8'hc3, port_zero_strong & 8'hc3);
    chk("p2 oe", 8'hed, port_two_oe);
    {ext_addr_phase, ext_data_out, ext_wdata} <= {2'b01, 8'h96};
    settle();
    chk("p0 wdata", 8'h96, port_zero_out);
    chk("p0 oe", 8'hff, port_zero_oe);
    ext_data_out <= 1'b0;
    p0_drv <= 8'h3c;
    settle();
    chk("p0 oe", 8'h00, port_zero_oe);
    chk("ext rdata", 8'h3c, ext_rdata);
    ext_access <= 1'b0;
    p0_drv <= 8'hff;
    $display("bus test done");
    analog_digital_input_port <= 8'ha5;
    rd_chk(`MPP_ADDR_ANALOG_IN, 8'ha5);
    wr(`MPP_ADDR_ANALOG_IN, 8'h00);
    analog_digital_input_port <= 8'h3c;
    rd_chk(`MPP_ADDR_ANALOG_IN, 8'h3c);
    rd_chk(8'h81, 8'h00);
    $display("input port test done");
    wr(`MPP_ADDR_PORT_ONE, 8'h00);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rd_chk(`MPP_ADDR_PORT_ONE, 8'hff);
    chk("p0 oe", 8'h00, port_zero_oe);
    $display("second reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> hdl/mpp_ports.sv
// Six bidirectional ports, input-only analog/digital port, SFR access.
// Assumes the core supplies SFR strobes, bus cycle controls and
// alternate function outputs synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "mpp_params.svh"

// Function
// - First port is 8-bit open-drain; released pins float as inputs.
// - Ports one to five are quasi-bidirectional with pullups, reading high.
// - External access drives low address/data on port zero, high on two.
// - Port zero drives strong ones in bus address and write data phases.
// - Port one bits 0-3 are interrupt three-six, compare and capture.
// - Port one bit 4 is interrupt two, bit 5 timer reload trigger.
// - Port one bit 6 outputs clock, bit 7 third timer count/gate.
// - Port three bits 0-1 carry serial data and transmit or shift clock.
// - Port three bits 2-3 are interrupts zero/one and timer gates.
// - Port three bits 4-5 are timer zero and one count inputs.
// - Port three bits 6-7 output external write and read strobes.
// - Reading the input-only port returns its present pin levels.
// - Input-only port needs no mode; digital read alongside converter.
// - Input-only port has no output drivers.
// - Port zero pin with latch one floats.
// - Quasi pin with latch one is pulled high by its pullup.
module mpp_ports (
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           reset,
  // Special function register access
  input  wire logic [7:0]     sfr_addr,
  input  wire logic           sfr_wr,
  input  wire logic           sfr_rd,
  input  wire mpp_pkg::mpp_byte_t sfr_wdata,
  output logic      [7:0]     sfr_rdata,
  // External memory cycle
  input  wire logic           ext_addr_phase,
  input  wire logic           ext_data_out,
  input  wire logic           ext_access,
  input  wire logic           ext_data_access,
  input  wire logic [15:0]    ext_addr,
  input  wire logic [7:0]     ext_wdata,
  output logic      [7:0]     ext_rdata,
  input  wire logic           ext_wr_n,
  input  wire logic           ext_rd_n,
  // Alternate function outputs from peripherals
  input  wire logic [3:0]     ccu_compare_out,
  input  wire logic           system_clock_src,
  input  wire logic           serial_data_out,
  input  wire logic           serial_txd_or_clk,
  // Alternate function inputs to peripherals
  output logic [3:0]          irq_three_ccu_chan_zero_pin,
  output logic                irq_two_pin,
  output logic                third_timer_reload_trigger,
  output logic                third_timer_count_gate_pin,
  output logic                serial_data_in,
  output logic                irq_zero_pin,
  output logic                irq_one_pin,
  output logic                timer_zero_count_pin,
  output logic                timer_one_count_pin,
  // Analog/digital input-only pins
  input  wire logic [7:0]     analog_digital_input_port,
  // Port zero pins: oe high drives, strong marks active pullup
  input  wire logic [7:0]     port_zero_in,
  output logic      [7:0]     port_zero_out,
  output logic      [7:0]     port_zero_oe,
  output logic      [7:0]     port_zero_strong,
  // Quasi-bidirectional pins: oe high drives low, pullup otherwise
  input  wire logic [7:0]     port_one_in,
  output logic      [7:0]     port_one_out,
  output logic      [7:0]     port_one_oe,
  input  wire logic [7:0]     port_two_in,
  output logic      [7:0]     port_two_out,
  output logic      [7:0]     port_two_oe,
  input  wire logic [7:0]     port_three_in,
  output logic      [7:0]     port_three_out,
  output logic      [7:0]     port_three_oe,
  input  wire logic [7:0]     port_four_in,
  output logic      [7:0]     port_four_out,
  output logic      [7:0]     port_four_oe,
  input  wire logic [7:0]     port_five_in,
  output logic      [7:0]     port_five_out,
  output logic      [7:0]     port_five_oe
);
  import mpp_pkg::*;

  mpp_state_s state_r;
  mpp_state_s state_nxt;

  // ========================================================
  // Quasi-bidirectional drive: a zero pulls low, a one uses pullup
  function automatic mpp_byte_t quasi_oe(input mpp_byte_t level);
    quasi_oe = ~level;
  endfunction

  // ========================================================
  // Register next state and read mux
  always_comb begin
    state_nxt       = state_r;
    state_nxt.rdata = `MPP_READ_NONE;
    if (sfr_wr) begin
      if (sfr_addr == `MPP_ADDR_PORT_ZERO) begin
        state_nxt.p0 = sfr_wdata;
      end else if (sfr_addr == `MPP_ADDR_PORT_ONE) begin
        state_nxt.p1 = sfr_wdata;
      end else if (sfr_addr == `MPP_ADDR_PORT_TWO) begin
        state_nxt.p2 = sfr_wdata;
      end else if (sfr_addr == `MPP_ADDR_PORT_THREE) begin
        state_nxt.p3 = sfr_wdata;
      end else if (sfr_addr == `MPP_ADDR_PORT_FOUR) begin
        state_nxt.p4 = sfr_wdata;
      end else if (sfr_addr == `MPP_ADDR_PORT_FIVE) begin
        state_nxt.p5 = sfr_wdata;
      end
    end
    // Writes to the input-only port are ignored
    if (sfr_rd) begin
      if (sfr_addr == `MPP_ADDR_PORT_ZERO) begin
        state_nxt.rdata = port_zero_in;
      end else if (sfr_addr == `MPP_ADDR_PORT_ONE) begin
        state_nxt.rdata = port_one_in;
      end else if (sfr_addr == `MPP_ADDR_PORT_TWO) begin
        state_nxt.rdata = port_two_in;
      end else if (sfr_addr == `MPP_ADDR_PORT_THREE) begin
        state_nxt.rdata = port_three_in;
      end else if (sfr_addr == `MPP_ADDR_ANALOG_IN) begin
        state_nxt.rdata = analog_digital_input_port;
      end else if (sfr_addr == `MPP_ADDR_PORT_FOUR) begin
        state_nxt.rdata = port_four_in;
      end else if (sfr_addr == `MPP_ADDR_PORT_FIVE) begin
        state_nxt.rdata = port_five_in;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r.p0    <= `MPP_LATCH_RESET;
      state_r.p1    <= `MPP_LATCH_RESET;
      state_r.p2    <= `MPP_LATCH_RESET;
      state_r.p3    <= `MPP_LATCH_RESET;
      state_r.p4    <= `MPP_LATCH_RESET;
      state_r.p5    <= `MPP_LATCH_RESET;
      state_r.rdata <= `MPP_READ_NONE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sfr_rdata = state_r.rdata;
  assign ext_rdata = port_zero_in;

  // ========================================================
  // Port zero: open drain, or bus with strong pullup
  mpp_byte_t p0_level;
  mpp_byte_t p2_level;
  mpp_byte_t p3_level;
  mpp_byte_t p1_level;
  always_comb begin
    p0_level = ext_addr_phase ? ext_addr[7:0] : ext_wdata;
  end
  always_comb begin
    if (ext_access && (ext_addr_phase || ext_data_out)) begin
      port_zero_out    = p0_level;
      port_zero_oe     = 8'hff;
      port_zero_strong = p0_level;
    end else if (ext_access) begin
      port_zero_out    = 8'h00; // Data read phase: released
      port_zero_oe     = 8'h00;
      port_zero_strong = 8'h00;
    end else begin
      port_zero_out    = 8'h00;
      port_zero_oe     = ~state_r.p0;
      port_zero_strong = 8'h00;
    end
  end

  // ========================================================
  // Quasi ports and alternate functions
  always_comb begin
    p2_level = ext_access ? ext_addr[15:8] : state_r.p2;
    p1_level = state_r.p1;
    p1_level[3:0] = state_r.p1[3:0] & ccu_compare_out;
    p1_level[`MPP_BIT_SYSTEM_CLOCK_OUT_PIN+3] = state_r.p1[`MPP_BIT_SYSTEM_CLOCK_OUT_PIN+3]
                                  & system_clock_src;
    p3_level = state_r.p3;
    p3_level[0] = state_r.p3[0] & serial_data_out;
    p3_level[1] = state_r.p3[1] & serial_txd_or_clk;
    if (ext_data_access) begin
      p3_level[`MPP_BIT_WR] = state_r.p3[`MPP_BIT_WR] & ext_wr_n;
      p3_level[`MPP_BIT_RD] = state_r.p3[`MPP_BIT_RD] & ext_rd_n;
    end
  end

  assign port_one_out   = 8'h00;
  assign port_one_oe    = quasi_oe(p1_level);
  assign port_two_out   = 8'h00;
  assign port_two_oe    = quasi_oe(p2_level);
  assign port_three_out = 8'h00;
  assign port_three_oe  = quasi_oe(p3_level);
  assign port_four_out  = 8'h00;
  assign port_four_oe   = quasi_oe(state_r.p4);
  assign port_five_out  = 8'h00;
  assign port_five_oe   = quasi_oe(state_r.p5);

  // Alternate inputs taken from the pins
  assign irq_three_ccu_chan_zero_pin = port_one_in[3:0];
  assign irq_two_pin                 = port_one_in[4];
  assign third_timer_reload_trigger  = port_one_in[5];
  assign third_timer_count_gate_pin  = port_one_in[7];
  assign serial_data_in              = port_three_in[0];
  assign irq_zero_pin                = port_three_in[2];
  assign irq_one_pin                 = port_three_in[3];
  assign timer_zero_count_pin        = port_three_in[4];
  assign timer_one_count_pin         = port_three_in[5];

  // ========================================================
  // Checks
  property latch_write_p(logic [7:0] a, logic [7:0] q);
    @(posedge sys_clk) disable iff (reset)
      (sfr_wr && sfr_addr == a) |=> (q == $past(sfr_wdata));
  endproperty
  sequence ext_on_s;
    ext_access && ext_addr_phase;
  endsequence

  p0_write_a: assert property (latch_write_p(`MPP_ADDR_PORT_ZERO,
    state_r.p0)) else $error("port zero latch not written");
  reset_ones_a: assert property (@(posedge sys_clk)
    reset |=> (state_r.p1 == `MPP_LATCH_RESET &&
    state_r.p5 == `MPP_LATCH_RESET))
    else $error("latches not ones after reset");
  bus_drive_a: assert property (@(posedge sys_clk) disable iff (reset)
    ext_on_s |-> (port_zero_oe == 8'hff &&
    port_zero_out == ext_addr[7:0] && port_two_oe == ~ext_addr[15:8]))
    else $error("address not on bus ports");
  strong_one_a: assert property (@(posedge sys_clk) disable iff (reset)
    ext_on_s |-> port_zero_strong == ext_addr[7:0])
    else $error("strong pullup missing");
  p0_float_a: assert property (@(posedge sys_clk) disable iff (reset)
    !ext_access |-> (port_zero_oe & state_r.p0) == 8'h00)
    else $error("port zero drives released pin");
  quasi_pull_a: assert property (@(posedge sys_clk) disable iff (reset)
    (port_four_oe & state_r.p4) == 8'h00 && port_four_out == 8'h00)
    else $error("quasi pin driven high");
  analog_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    (sfr_rd && sfr_addr == `MPP_ADDR_ANALOG_IN) |=>
    sfr_rdata == $past(analog_digital_input_port))
    else $error("input port read wrong");
  strobe_out_a: assert property (@(posedge sys_clk) disable iff (reset)
    (ext_data_access && !ext_wr_n) |-> port_three_oe[`MPP_BIT_WR])
    else $error("write strobe not driven");
  irq_map_a: assert property (@(posedge sys_clk) disable iff (reset)
    irq_zero_pin == port_three_in[2] && irq_two_pin == port_one_in[4])
    else $error("interrupt pin mapping wrong");

  // ========================================================
  // Further pin and bus checks
  sequence ext_write_data_s;
    ext_access && !ext_addr_phase && ext_data_out;
  endsequence
  bus_wdata_a: assert property (@(posedge sys_clk) disable iff (reset)
    ext_write_data_s |-> (port_zero_out == ext_wdata &&
    port_zero_oe == 8'hff))
    else $error("write data not on port zero");
  ext_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    ext_rdata == port_zero_in)
    else $error("external read data wrong");
  quasi_two_a: assert property (@(posedge sys_clk) disable iff (reset)
    !ext_access |-> (port_two_oe == ~state_r.p2 &&
    port_two_out == 8'h00))
    else $error("port two not quasi");
  ccu_drive_a: assert property (@(posedge sys_clk) disable iff (reset)
    port_one_oe[3:0] == ~(state_r.p1[3:0] & ccu_compare_out))
    else $error("compare output drive wrong");
  clock_out_a: assert property (@(posedge sys_clk) disable iff (reset)
    port_one_oe[6] == ~(state_r.p1[6] & system_clock_src))
    else $error("clock output drive wrong");
  reload_map_a: assert property (@(posedge sys_clk) disable iff (reset)
    third_timer_reload_trigger == port_one_in[5] &&
    third_timer_count_gate_pin == port_one_in[7])
    else $error("third timer pin mapping wrong");
  serial_map_a: assert property (@(posedge sys_clk) disable iff (reset)
    serial_data_in == port_three_in[0] && port_three_oe[1:0] ==
    ~(state_r.p3[1:0] & {serial_txd_or_clk, serial_data_out}))
    else $error("serial pin mapping wrong");
  count_map_a: assert property (@(posedge sys_clk) disable iff (reset)
    timer_zero_count_pin == port_three_in[4] &&
    timer_one_count_pin == port_three_in[5])
    else $error("timer count pin mapping wrong");
  analog_nowr_a: assert property (@(posedge sys_clk) disable iff (reset)
    (sfr_wr && sfr_addr == `MPP_ADDR_ANALOG_IN) |=>
    {state_r.p0, state_r.p1, state_r.p2, state_r.p3, state_r.p4,
    state_r.p5} == $past({state_r.p0, state_r.p1, state_r.p2,
    state_r.p3, state_r.p4, state_r.p5}))
    else $error("input port write changed a latch");
  gate_map_a: assert property (@(posedge sys_clk) disable iff (reset)
    irq_one_pin == port_three_in[3] &&
    irq_three_ccu_chan_zero_pin == port_one_in[3:0])
    else $error("gate or capture pin mapping wrong");

endmodule
`default_nettype wire

// >>> pkg/mpp_params.svh
// Port block constants: register addresses, reset values, bit positions.
// Assumes an 8-bit special function register address space.
`ifndef MPP_PARAMS_SVH
`define MPP_PARAMS_SVH
// ==========================================================
// Register addresses
`define MPP_ADDR_PORT_ZERO  8'h80
`define MPP_ADDR_PORT_ONE   8'h90
`define MPP_ADDR_PORT_TWO   8'ha0
`define MPP_ADDR_PORT_THREE 8'hb0
`define MPP_ADDR_ANALOG_IN  8'hdb
`define MPP_ADDR_PORT_FOUR  8'he8
`define MPP_ADDR_PORT_FIVE  8'hf8
// ==========================================================
// Reset values and read defaults
`define MPP_LATCH_RESET     8'hff
`define MPP_READ_NONE       8'h00
// ==========================================================
// Alternate function bit positions
`define MPP_BIT_SYSTEM_CLOCK_OUT_PIN      3
`define MPP_BIT_WR          6
`define MPP_BIT_RD          7
`endif

// >>> pkg/mpp_pkg.sv
// Types of the parallel port block.
// Assumes the params header is included by users of the constants.
package mpp_pkg;
  typedef logic [7:0] mpp_byte_t;
  typedef struct packed {
    mpp_byte_t p0;
    mpp_byte_t p1;
    mpp_byte_t p2;
    mpp_byte_t p3;
    mpp_byte_t p4;
    mpp_byte_t p5;
    mpp_byte_t rdata;
  } mpp_state_s;
endpackage
